// ### core/ifsb_top.v
`timescale 1ns/1ps
`include "ifsb_regs.vh"

//
// Contract
// - A flag reads one once its source raised a request or software wrote one, until software clears it.
// - Software can read and write every implemented flag bit.
// - All implemented flags are zero after power-on reset.
// - Unimplemented bit positions always read zero.
// - Flags 1 holds change notify, I2C one master and slave flags.
// - Flags 2 upper bits hold timer six, DMA four, compares, captures six-three.
// - Flags 2 low bits hold DMA three, CAN one event/receive, SPI two.
// - Flags 3 holds DMA five, CAN two event/receive, external four and three.
// - Flags 3 low bits hold timers nine, eight, seven and I2C two.
// - Flags 4 holds CAN transmit, DMA seven and six, UART errors.
module ifsb_top (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_n_in,
  // Peripheral request pulses, one bit per flag position
  input  wire [3:0]  event_flags_1_in,
  input  wire [15:0] event_flags_2_in,
  input  wire [15:0] event_flags_3_in,
  input  wire [15:0] event_flags_4_in,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // Flag state towards the processor interrupt logic
  output reg  [15:0] flags_1_out,
  output reg  [15:0] flags_2_out,
  output reg  [15:0] flags_3_out,
  output reg  [15:0] flags_4_out,
  output reg         irq_out
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------

  // Next value of one flag register. The request pulses are ORed in after the
  // software write, so a set in the same cycle as a clear wins.
  function [15:0] ifsb_next_flags;
    input [15:0] cur;
    input [15:0] ev;
    input [15:0] wdata;
    input [1:0]  strb;
    input        we;
    input [15:0] impl;
    reg   [15:0] lane;
    begin
      lane = {{8{strb[1] & we}}, {8{strb[0] & we}}};
      ifsb_next_flags = ((cur & ~lane) | (wdata & lane) | ev) & impl;
    end
  endfunction

  // One-hot decode of a register byte address; zero for an unmapped address.
  function [5:0] ifsb_decode;
    input [7:0] addr;
    begin
      case (addr)
        `IFSB_OFS_FLAGS_1:      ifsb_decode = 6'h01;
        `IFSB_OFS_FLAGS_2:      ifsb_decode = 6'h02;
        `IFSB_OFS_FLAGS_3:      ifsb_decode = 6'h04;
        `IFSB_OFS_FLAGS_4:      ifsb_decode = 6'h08;
        `IFSB_OFS_EVENT_STATUS: ifsb_decode = 6'h10;
        `IFSB_OFS_EVENT_MASK:   ifsb_decode = 6'h20;
        default:                ifsb_decode = 6'h00;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  reg        rst_meta;
  reg        rst_sync;

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------------------
  reg        aw_held;
  reg [7:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [3:0]  event_status;
  reg [3:0]  event_mask;

  wire       aw_fire    = s_axi_awvalid_in & s_axi_awready_out;
  wire       w_fire     = s_axi_wvalid_in & s_axi_wready_out;
  wire       do_write   = aw_held & w_held & ~s_axi_bvalid_out;
  wire [5:0] wr_sel     = ifsb_decode(aw_addr);
  wire       next_aw_held = do_write ? 1'b0 : (aw_held | aw_fire);
  wire       next_w_held  = do_write ? 1'b0 : (w_held | w_fire);
  wire       next_bvalid  = do_write ? 1'b1 : (s_axi_bvalid_out & ~s_axi_bready_in);

  always @(posedge clock_in or negedge rst_sync) begin
    if (!rst_sync) begin
      aw_held           <= 1'b0;
      aw_addr           <= 8'h00;
      w_held            <= 1'b0;
      w_data            <= 32'h00000000;
      w_strb            <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `IFSB_RESP_OKAY;
    end else begin
      aw_held           <= next_aw_held;
      w_held            <= next_w_held;
      s_axi_bvalid_out  <= next_bvalid;
      // Address and data are taken independently; each ready drops while its
      // item is held or a response is pending, which bounds one write in flight.
      s_axi_awready_out <= ~next_aw_held & ~next_bvalid;
      s_axi_wready_out  <= ~next_w_held & ~next_bvalid;
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr_in;
      end
      if (w_fire) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (do_write) begin
        s_axi_bresp_out <= (wr_sel == 6'h00) ? `IFSB_RESP_SLVERR : `IFSB_RESP_OKAY;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Request lines
  // ---------------------------------------------------------------------------
  // Each source gets a named request line; positions without a source are
  // tied low when the words are built, so their input bits are never read.
  wire set_change_notify_flag    = event_flags_1_in[`IFSB_CHANGE_NOTIFY_FLAG];
  wire set_i2c_one_master_flag   = event_flags_1_in[`IFSB_I2C_ONE_MASTER_FLAG];
  wire set_i2c_one_slave_flag    = event_flags_1_in[`IFSB_I2C_ONE_SLAVE_FLAG];
  wire set_timer_six_flag        = event_flags_2_in[`IFSB_TIMER_SIX_FLAG];
  wire set_dma_four_done_flag    = event_flags_2_in[`IFSB_DMA_FOUR_DONE_FLAG];
  wire set_compare_eight_flag    = event_flags_2_in[`IFSB_COMPARE_EIGHT_FLAG];
  wire set_compare_seven_flag    = event_flags_2_in[`IFSB_COMPARE_SEVEN_FLAG];
  wire set_compare_six_flag      = event_flags_2_in[`IFSB_COMPARE_SIX_FLAG];
  wire set_compare_five_flag     = event_flags_2_in[`IFSB_COMPARE_FIVE_FLAG];
  wire set_capture_six_flag      = event_flags_2_in[`IFSB_CAPTURE_SIX_FLAG];
  wire set_capture_five_flag     = event_flags_2_in[`IFSB_CAPTURE_FIVE_FLAG];
  wire set_capture_four_flag     = event_flags_2_in[`IFSB_CAPTURE_FOUR_FLAG];
  wire set_capture_three_flag    = event_flags_2_in[`IFSB_CAPTURE_THREE_FLAG];
  wire set_dma_three_done_flag   = event_flags_2_in[`IFSB_DMA_THREE_DONE_FLAG];
  wire set_can_one_event_flag    = event_flags_2_in[`IFSB_CAN_ONE_EVENT_FLAG];
  wire set_can_one_receive_flag  = event_flags_2_in[`IFSB_CAN_ONE_RECEIVE_FLAG];
  wire set_spi_two_event_flag    = event_flags_2_in[`IFSB_SPI_TWO_EVENT_FLAG];
  wire set_spi_two_error_flag    = event_flags_2_in[`IFSB_SPI_TWO_ERROR_FLAG];
  wire set_dma_five_done_flag    = event_flags_3_in[`IFSB_DMA_FIVE_DONE_FLAG];
  wire set_can_two_event_flag    = event_flags_3_in[`IFSB_CAN_TWO_EVENT_FLAG];
  wire set_can_two_receive_flag  = event_flags_3_in[`IFSB_CAN_TWO_RECEIVE_FLAG];
  wire set_external_four_flag    = event_flags_3_in[`IFSB_EXTERNAL_FOUR_FLAG];
  wire set_external_three_flag   = event_flags_3_in[`IFSB_EXTERNAL_THREE_FLAG];
  wire set_timer_nine_flag       = event_flags_3_in[`IFSB_TIMER_NINE_FLAG];
  wire set_timer_eight_flag      = event_flags_3_in[`IFSB_TIMER_EIGHT_FLAG];
  wire set_i2c_two_master_flag   = event_flags_3_in[`IFSB_I2C_TWO_MASTER_FLAG];
  wire set_i2c_two_slave_flag    = event_flags_3_in[`IFSB_I2C_TWO_SLAVE_FLAG];
  wire set_timer_seven_flag      = event_flags_3_in[`IFSB_TIMER_SEVEN_FLAG];
  wire set_can_two_transmit_flag = event_flags_4_in[`IFSB_CAN_TWO_TRANSMIT_FLAG];
  wire set_can_one_transmit_flag = event_flags_4_in[`IFSB_CAN_ONE_TRANSMIT_FLAG];
  wire set_dma_seven_done_flag   = event_flags_4_in[`IFSB_DMA_SEVEN_DONE_FLAG];
  wire set_dma_six_done_flag     = event_flags_4_in[`IFSB_DMA_SIX_DONE_FLAG];
  wire set_uart_two_error_flag   = event_flags_4_in[`IFSB_UART_TWO_ERROR_FLAG];
  wire set_uart_one_error_flag   = event_flags_4_in[`IFSB_UART_ONE_ERROR_FLAG];

  // ---------------------------------------------------------------------------
  // Flag registers
  // ---------------------------------------------------------------------------
  wire [15:0] ev_1 = {12'h000,
                      set_change_notify_flag,
                      1'b0,
                      set_i2c_one_master_flag,
                      set_i2c_one_slave_flag};
  wire [15:0] ev_2 = {set_timer_six_flag,
                      set_dma_four_done_flag,
                      1'b0,
                      set_compare_eight_flag,
                      set_compare_seven_flag,
                      set_compare_six_flag,
                      set_compare_five_flag,
                      set_capture_six_flag,
                      set_capture_five_flag,
                      set_capture_four_flag,
                      set_capture_three_flag,
                      set_dma_three_done_flag,
                      set_can_one_event_flag,
                      set_can_one_receive_flag,
                      set_spi_two_event_flag,
                      set_spi_two_error_flag};
  wire [15:0] ev_3 = {2'b00,
                      set_dma_five_done_flag,
                      4'h0,
                      set_can_two_event_flag,
                      set_can_two_receive_flag,
                      set_external_four_flag,
                      set_external_three_flag,
                      set_timer_nine_flag,
                      set_timer_eight_flag,
                      set_i2c_two_master_flag,
                      set_i2c_two_slave_flag,
                      set_timer_seven_flag};
  wire [15:0] ev_4 = {8'h00,
                      set_can_two_transmit_flag,
                      set_can_one_transmit_flag,
                      set_dma_seven_done_flag,
                      set_dma_six_done_flag,
                      1'b0,
                      set_uart_two_error_flag,
                      set_uart_one_error_flag,
                      1'b0};

  wire [15:0] next_flags_1 = ifsb_next_flags(flags_1_out, ev_1, w_data[15:0], w_strb[1:0],
                                             do_write & wr_sel[0], `IFSB_IMPL_FLAGS_1);
  wire [15:0] next_flags_2 = ifsb_next_flags(flags_2_out, ev_2, w_data[15:0], w_strb[1:0],
                                             do_write & wr_sel[1], `IFSB_IMPL_FLAGS_2);
  wire [15:0] next_flags_3 = ifsb_next_flags(flags_3_out, ev_3, w_data[15:0], w_strb[1:0],
                                             do_write & wr_sel[2], `IFSB_IMPL_FLAGS_3);
  wire [15:0] next_flags_4 = ifsb_next_flags(flags_4_out, ev_4, w_data[15:0], w_strb[1:0],
                                             do_write & wr_sel[3], `IFSB_IMPL_FLAGS_4);

  // Summary event bits: one per flag register, write one to clear, set wins.
  wire [3:0]  ev_any     = {|ev_4, |ev_3, |ev_2, |ev_1};
  wire [3:0]  status_clr = (do_write & wr_sel[4] & w_strb[0]) ? w_data[3:0] : 4'h0;
  wire [3:0]  next_event_status = (event_status & ~status_clr) | ev_any;

  always @(posedge clock_in or negedge rst_sync) begin
    if (!rst_sync) begin
      flags_1_out <= `IFSB_RST_FLAGS;
    end else begin
      flags_1_out <= next_flags_1;
    end
  end

  always @(posedge clock_in or negedge rst_sync) begin
    if (!rst_sync) begin
      flags_2_out <= `IFSB_RST_FLAGS;
    end else begin
      flags_2_out <= next_flags_2;
    end
  end

  always @(posedge clock_in or negedge rst_sync) begin
    if (!rst_sync) begin
      flags_3_out <= `IFSB_RST_FLAGS;
    end else begin
      flags_3_out <= next_flags_3;
    end
  end

  always @(posedge clock_in or negedge rst_sync) begin
    if (!rst_sync) begin
      flags_4_out <= `IFSB_RST_FLAGS;
    end else begin
      flags_4_out <= next_flags_4;
    end
  end

  always @(posedge clock_in or negedge rst_sync) begin
    if (!rst_sync) begin
      event_status <= `IFSB_RST_EVENT;
      event_mask   <= `IFSB_RST_EVENT;
      irq_out      <= 1'b0;
    end else begin
      event_status <= next_event_status;
      if (do_write & wr_sel[5] & w_strb[0]) begin
        event_mask <= w_data[3:0];
      end
      irq_out      <= |(event_status & event_mask);
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  wire [5:0] rd_sel = ifsb_decode(s_axi_araddr_in);
  wire       ar_fire = s_axi_arvalid_in & s_axi_arready_out;
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    case (rd_sel)
      6'h01:   rd_word = {16'h0000, flags_1_out};
      6'h02:   rd_word = {16'h0000, flags_2_out};
      6'h04:   rd_word = {16'h0000, flags_3_out};
      6'h08:   rd_word = {16'h0000, flags_4_out};
      6'h10:   rd_word = {28'h0000000, event_status};
      6'h20:   rd_word = {28'h0000000, event_mask};
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge clock_in or negedge rst_sync) begin
    if (!rst_sync) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `IFSB_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_word;
        s_axi_rresp_out   <= (rd_sel == 6'h00) ? `IFSB_RESP_SLVERR : `IFSB_RESP_OKAY;
      end else if (s_axi_rvalid_out & s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end else if (~s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
      end
    end
  end

endmodule // ifsb_top

// ### core/ifsb_regs.vh
`ifndef IFSB_REGS_VH
`define IFSB_REGS_VH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define IFSB_OFS_FLAGS_1       8'h00
`define IFSB_OFS_FLAGS_2       8'h04
`define IFSB_OFS_FLAGS_3       8'h08
`define IFSB_OFS_FLAGS_4       8'h0C
`define IFSB_OFS_EVENT_STATUS  8'h10
`define IFSB_OFS_EVENT_MASK    8'h14

// -----------------------------------------------------------------------------
// Implemented bit masks and reset values
// -----------------------------------------------------------------------------
`define IFSB_IMPL_FLAGS_1      16'h000B
`define IFSB_IMPL_FLAGS_2      16'hDFFF
`define IFSB_IMPL_FLAGS_3      16'h21FF
`define IFSB_IMPL_FLAGS_4      16'h00F6
`define IFSB_RST_FLAGS         16'h0000
`define IFSB_RST_EVENT         4'h0

// -----------------------------------------------------------------------------
// Flag bit positions
// -----------------------------------------------------------------------------
`define IFSB_CHANGE_NOTIFY_FLAG     3
`define IFSB_I2C_ONE_MASTER_FLAG    1
`define IFSB_I2C_ONE_SLAVE_FLAG     0
`define IFSB_TIMER_SIX_FLAG         15
`define IFSB_DMA_FOUR_DONE_FLAG     14
`define IFSB_COMPARE_EIGHT_FLAG     12
`define IFSB_COMPARE_SEVEN_FLAG     11
`define IFSB_COMPARE_SIX_FLAG       10
`define IFSB_COMPARE_FIVE_FLAG      9
`define IFSB_CAPTURE_SIX_FLAG       8
`define IFSB_CAPTURE_FIVE_FLAG      7
`define IFSB_CAPTURE_FOUR_FLAG      6
`define IFSB_CAPTURE_THREE_FLAG     5
`define IFSB_DMA_THREE_DONE_FLAG    4
`define IFSB_CAN_ONE_EVENT_FLAG     3
`define IFSB_CAN_ONE_RECEIVE_FLAG   2
`define IFSB_SPI_TWO_EVENT_FLAG     1
`define IFSB_SPI_TWO_ERROR_FLAG     0
`define IFSB_DMA_FIVE_DONE_FLAG     13
`define IFSB_CAN_TWO_EVENT_FLAG     8
`define IFSB_CAN_TWO_RECEIVE_FLAG   7
`define IFSB_EXTERNAL_FOUR_FLAG     6
`define IFSB_EXTERNAL_THREE_FLAG    5
`define IFSB_TIMER_NINE_FLAG        4
`define IFSB_TIMER_EIGHT_FLAG       3
`define IFSB_I2C_TWO_MASTER_FLAG    2
`define IFSB_I2C_TWO_SLAVE_FLAG     1
`define IFSB_TIMER_SEVEN_FLAG       0
`define IFSB_CAN_TWO_TRANSMIT_FLAG  7
`define IFSB_CAN_ONE_TRANSMIT_FLAG  6
`define IFSB_DMA_SEVEN_DONE_FLAG    5
`define IFSB_DMA_SIX_DONE_FLAG      4
`define IFSB_UART_TWO_ERROR_FLAG    2
`define IFSB_UART_ONE_ERROR_FLAG    1

// -----------------------------------------------------------------------------
// Bus responses
// -----------------------------------------------------------------------------
`define IFSB_RESP_OKAY         2'h0
`define IFSB_RESP_SLVERR       2'h2

`endif

// ### verif/ifsb_sva.sv
`timescale 1ns/1ps
`include "ifsb_regs.vh"
module ifsb_sva (
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  // Observed ports
  input wire logic [15:0] event_flags_2_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [15:0] flags_1_out,
  input wire logic [15:0] flags_2_out,
  input wire logic [15:0] flags_3_out,
  input wire logic [15:0] flags_4_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_unimpl_zero: assert property (((flags_1_out & ~`IFSB_IMPL_FLAGS_1) | (flags_2_out & ~`IFSB_IMPL_FLAGS_2)
    | (flags_3_out & ~`IFSB_IMPL_FLAGS_3) | (flags_4_out & ~`IFSB_IMPL_FLAGS_4)) == 16'h0000)
    else $error("unimplemented flag bit set");
  chk_event_sets: assert property (|event_flags_2_in |=>
    (flags_2_out & $past(event_flags_2_in) & `IFSB_IMPL_FLAGS_2) == ($past(event_flags_2_in) & `IFSB_IMPL_FLAGS_2))
    else $error("request pulse did not set its flag");
  // A flags 2 bit may only fall together with the response of the write that cleared it.
  chk_flag_holds: assert property (|($past(flags_2_out) & ~flags_2_out) |-> s_axi_bvalid_out)
    else $error("flag fell without a write");
  chk_reset_clear: assert property ($rose(rst_n_in) |->
    {flags_1_out, flags_2_out, flags_3_out, flags_4_out, irq_out} == 65'h0)
    else $error("state not clear after reset");
  chk_write_resp: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out) else $error("write response late or early");
  chk_bresp_done: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response not retired");
  chk_read_turn: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer not one cycle after address");
  chk_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address accepted while data pending");
  cover property ($rose(irq_out));
  cover property ($fell(flags_2_out[15]));
  cover property (s_axi_rvalid_out);
endmodule // ifsb_sva

bind ifsb_top ifsb_sva i_sva (.*);

// ### verif/ifsb_event_src.sv
`timescale 1ns/1ps
module ifsb_event_src (
  // Clock
  input wire logic        clock_in,
  // Request pulses towards the flag bank
  output logic [3:0][15:0] ev_out
);
  initial ev_out = 64'h0;
  // Callers sit just after a rising edge, so a pulse spans exactly one sampling edge.
  task automatic pulse(input int r, input logic [15:0] v);
    ev_out[r] <= v;
    @(posedge clock_in);
    ev_out[r] <= 16'h0000;
  endtask
endmodule // ifsb_event_src

// ### verif/ifsb_tb.sv
`timescale 1ns/1ps
`include "ifsb_regs.vh"
module ifsb_tb;
  localparam logic [3:0][15:0] IMPL = {`IFSB_IMPL_FLAGS_4, `IFSB_IMPL_FLAGS_3, `IFSB_IMPL_FLAGS_2, `IFSB_IMPL_FLAGS_1};
  logic clock_in = 1'b0, rst_n_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [15:0] flags_1_out, flags_2_out, flags_3_out, flags_4_out;
  logic [3:0][15:0] ev;
  wire [3:0][15:0] fl = {flags_4_out, flags_3_out, flags_2_out, flags_1_out};
  int fails = 0, samples_checked = 0;
  ifsb_event_src i_src (.clock_in(clock_in), .ev_out(ev));
  ifsb_top i_dut (.event_flags_1_in(ev[0][3:0]), .event_flags_2_in(ev[1]), .event_flags_3_in(ev[2]),
                  .event_flags_4_in(ev[3]), .*);
  initial begin
    forever #10 clock_in = ~clock_in;
  end
  task automatic report_and_stop;
    $display("Compared %0d values, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every wait in axw and axr goes through here, so a silent slave ends the run.
  task automatic tick(inout int n);
    @(posedge clock_in);
    n++;
    if (n > 60) begin
      fails++;
      report_and_stop;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] er = `IFSB_RESP_OKAY);
    logic ad, dd;
    int n;
    ad = 1'b1;
    dd = 1'b1;
    n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    while (ad || dd) begin
      tick(n);
      if (ad && s_axi_awready_out) begin ad = 1'b0; s_axi_awvalid_in <= 1'b0; end
      if (dd && s_axi_wready_out) begin dd = 1'b0; s_axi_wvalid_in <= 1'b0; end
    end
    s_axi_bready_in <= 1'b1;
    do tick(n); while (s_axi_bvalid_out !== 1'b1);
    check(s_axi_bresp_out, er);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = `IFSB_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do tick(n); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    s_axi_rready_in <= 1'b1;
    do tick(n); while (s_axi_rvalid_out !== 1'b1);
    check(s_axi_rdata_out, ed);
    check(s_axi_rresp_out, er);
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic t_write_back;
    for (int k = 0; k < 4; k++) begin
      axw(8'(4 * k), 32'hFFFFFFFF);
      axr(8'(4 * k), {16'h0000, IMPL[k]});
      axw(8'(4 * k), 32'h0);
      axr(8'(4 * k), 32'h0);
    end
    axw(8'h04, 32'hFFFF, 4'h1);
    axr(8'h04, 32'h00FF);
    axw(8'h04, 32'h0);
  endtask
  task automatic t_event_map;
    for (int k = 0; k < 4; k++)
      for (int b = 0; b < 16; b++) begin
        i_src.pulse(k, 16'h0001 << b);
        axr(8'(4 * k), {16'h0000, IMPL[k] & (16'h0001 << b)});
        check(fl[k], IMPL[k] & (16'h0001 << b));
        axw(8'(4 * k), 32'h0);
      end
  endtask
  task automatic t_set_wins;
    fork
      axw(8'h04, 32'h0);
      begin
        @(posedge clock_in iff (s_axi_awvalid_in && s_axi_awready_out));
        i_src.pulse(1, 16'h8000);
      end
    join
    axr(8'h04, 32'h8000);
    axw(8'h04, 32'h0);
    axr(8'h04, 32'h0);
  endtask
  task automatic t_irq;
    axw(8'h10, 32'hF, 4'h1);
    axr(8'h10, 32'h0);
    axw(8'h14, 32'h2, 4'h1);
    i_src.pulse(2, 16'h0001);
    axr(8'h10, 32'h4);
    check(irq_out, 1'b0);
    i_src.pulse(1, 16'h0001);
    axr(8'h10, 32'h6);
    check(irq_out, 1'b1);
    axw(8'h14, 32'h0, 4'h1);
    repeat (2) @(posedge clock_in);
    check(irq_out, 1'b0);
    axw(8'h10, 32'h2, 4'h1);
    axw(8'h14, 32'h2, 4'h1);
    axr(8'h10, 32'h4);
    check(irq_out, 1'b0);
    axw(8'h18, 32'hFFFFFFFF, 4'hF, `IFSB_RESP_SLVERR);
    axr(8'h18, 32'h0, `IFSB_RESP_SLVERR);
  endtask
  task automatic t_mid_reset;
    for (int k = 0; k < 4; k++) i_src.pulse(k, 16'hFFFF);
    axr(8'h08, {16'h0000, IMPL[2]});
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check(fl[1:0], 32'h0);
    check(fl[3:2], 32'h0);
    rst_n_in <= 1'b1;
    for (int k = 0; k < 6; k++) axr(8'(4 * k), 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int k = 0; k < 6; k++) axr(8'(4 * k), 32'h0);
    t_write_back;
    t_event_map;
    t_set_wins;
    t_irq;
    t_mid_reset;
    report_and_stop;
  end
endmodule // ifsb_tb
